//--- bench/amc_host.sv
// Host model driving the control port of the register block
module amc_host #(
  parameter int SETTLE_CYCLES = 16
) (
  input wire logic mclk_in,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire logic [7:0] reg_rdata_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  // Released lines are inverted so stale values never pass for live ones
  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk_in);
    reg_addr_out <= addr;
    reg_wdata_out <= data;
    reg_wr_out <= 1'b1;
    @(posedge mclk_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~addr;
    reg_wdata_out <= ~data;
  endtask
  task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge mclk_in);
    reg_addr_out <= addr;
    reg_rd_out <= 1'b1;
    @(posedge mclk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~addr;
    @(negedge mclk_in);
    data = reg_rdata_in;
  endtask
  // Settle wait is shortened; the real one is milliseconds long
  task automatic startup;
    wr_reg(8'h03, 8'h02);
    repeat (SETTLE_CYCLES) @(posedge mclk_in);
    wr_reg(8'h03, 8'h03);
  endtask
endmodule

//--- bench/test_amp_device_control_regs.sv
// Self-checking bench for the device control registers
module test_amp_device_control_regs;
  import amc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in;
  logic rst_in;
  logic [7:0] addr, wdata, rdata, rd_val, v;
  logic wr, rd, core_rst, coef_clr, topo, hold, mute, muted, page_dis;
  logic [2:0] fsw;
  logic [9:0] khz;
  logic [7:0] atten;
  amc_mod_e modsel;
  amc_pstate_e pstate;
  int failures;
  int n_tests;
  int i;
  logic [2:0] fsw_code [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
  logic [9:0] fsw_khz [4] = '{10'h300, 10'h180, 10'h1E0, 10'h240};
  logic [1:0] mods [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
  amc_host host (.mclk_in(mclk_in), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_rdata_in(rdata));
  amc_ctrl_regs #(.RAMP_STEP_CYCLES(2)) dut (.mclk_in(mclk_in),
    .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .core_reset_out(core_rst), .coef_clear_out(coef_clr),
    .switch_freq_select_out(fsw), .switch_freq_khz_out(khz),
    .bridge_topology_select_out(topo),
    .modulation_scheme_select_out(modsel),
    .processor_hold_reset_out(hold), .mute_req_out(mute),
    .mute_atten_out(atten), .muted_out(muted),
    .power_state_out(pstate), .page_inc_disable_out(page_dis));
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.rd_reg(a, rd_val);
    chk(rd_val, exp);
  endtask
  initial begin
    failures = 0;
    n_tests = 0;
    rst_in = 1'b1;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h10);
    chk(hold, 1'b1);
    chk(pstate, 2'h0);
    chk(page_dis, 1'b0);
    rd_chk(8'h0F, 8'h00);
    rd_chk(8'h04, 8'h00);
    // Only listed switch codes; reserved ones are never written
    for (i = 0; i < 4; i++) begin
      v = {1'b0, fsw_code[i], 1'b0, i[0], mods[i]};
      host.wr_reg(8'h02, v);
      repeat (2) @(negedge mclk_in);
      chk(khz, fsw_khz[i]);
      chk(fsw, fsw_code[i]);
      chk(topo, i[0]);
      chk(modsel, mods[i]);
      rd_chk(8'h02, v);
    end
    host.startup();
    @(negedge mclk_in);
    chk(pstate, 2'h3);
    chk(hold, 1'b0);
    for (i = 0; i < 4; i++) begin
      host.wr_reg(8'h03, {6'h00, i[1:0]});
      @(negedge mclk_in);
      chk(pstate, i[1:0]);
    end
    host.wr_reg(8'h03, 8'h0B);
    repeat (20) @(negedge mclk_in);
    chk(mute, 1'b1);
    chk(atten > 8'h05 && atten < 8'h0E, 1'b1);
    for (i = 0; i < 700 && muted !== 1'b1; i++) @(negedge mclk_in);
    chk(atten, 8'hFF);
    chk(muted, 1'b1);
    host.wr_reg(8'h03, 8'h03);
    for (i = 0; i < 700 && atten !== 8'h00; i++) @(negedge mclk_in);
    chk(atten, 8'h00);
    chk(muted, 1'b0);
    host.wr_reg(8'h0F, 8'h08);
    @(negedge mclk_in);
    chk(page_dis, 1'b1);
    rd_chk(8'h0F, 8'h08);
    host.wr_reg(8'h01, 8'hE0);
    rd_chk(8'h01, 8'hE0);
    host.wr_reg(8'h01, 8'h01);
    @(negedge mclk_in);
    chk(core_rst, 1'b0);
    chk(coef_clr, 1'b0);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h10);
    rd_chk(8'h0F, 8'h00);
    chk(page_dis, 1'b0);
    host.wr_reg(8'h02, 8'h45);
    host.wr_reg(8'h03, 8'h0B);
    host.wr_reg(8'h01, 8'h10);
    @(negedge mclk_in);
    chk(core_rst, 1'b1);
    chk(coef_clr, 1'b1);
    @(negedge mclk_in);
    chk(core_rst, 1'b0);
    chk(coef_clr, 1'b0);
    chk(atten, 8'h00);
    rd_chk(8'h03, 8'h10);
    rd_chk(8'h02, 8'h00);
    chk(hold, 1'b1);
    end_of_test;
  end
endmodule

//--- rtl/amc_ctrl_regs.sv
// Amplifier device control registers behind the control port
`include "amc_regs.svh"
module amc_ctrl_regs
  import amc_pkg::*;
#(
  parameter int RAMP_STEP_CYCLES = `AMC_RAMP_STEP_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic core_reset_out,
  output logic coef_clear_out,
  output logic [2:0] switch_freq_select_out,
  output logic [9:0] switch_freq_khz_out,
  output logic bridge_topology_select_out,
  output amc_mod_e modulation_scheme_select_out,
  output logic processor_hold_reset_out,
  output logic mute_req_out,
  output logic [7:0] mute_atten_out,
  output logic muted_out,
  output amc_pstate_e power_state_out,
  output logic page_inc_disable_out
);
  logic [2:0] srst_keep_reg;
  logic [7:0] amp_cfg_reg;
  logic [7:0] state_ctrl_reg;
  logic [7:0] page_inc_reg;
  logic core_pulse;
  logic regs_pulse;
  logic file_reset;
  logic wr_srst;
  logic wr_cfg;
  logic wr_state;
  logic wr_page;

  // Reserved codes give 0 so a bad host setting never looks like a rate
  function automatic logic [9:0] freq_khz(input logic [2:0] code);
    case (code)
      3'h0: freq_khz = 10'h300;
      3'h1: freq_khz = 10'h180;
      3'h3: freq_khz = 10'h1E0;
      3'h4: freq_khz = 10'h240;
      default: freq_khz = 10'h000;
    endcase
  endfunction

  assign wr_srst = reg_wr_in && reg_addr_in == `AMC_OFS_SOFT_RESET;
  assign wr_cfg = reg_wr_in && reg_addr_in == `AMC_OFS_AMP_CFG;
  assign wr_state = reg_wr_in && reg_addr_in == `AMC_OFS_STATE_CTRL;
  assign wr_page = reg_wr_in && reg_addr_in == `AMC_OFS_PAGE_INC;
  assign core_pulse = wr_srst && reg_wdata_in[`AMC_CORE_RST_BIT];
  assign regs_pulse = wr_srst && reg_wdata_in[`AMC_REGS_RST_BIT];
  assign file_reset = rst_in || core_pulse || regs_pulse;

  // Triggers are not stored, so they act once per write and read as 0
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      core_reset_out <= 1'b0;
      coef_clear_out <= 1'b0;
    end else begin
      core_reset_out <= core_pulse;
      coef_clear_out <= core_pulse;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (file_reset) begin
      srst_keep_reg <= 3'(`AMC_RST_SOFT_RESET >> `AMC_SRST_KEEP_LSB);
    end else if (wr_srst) begin
      srst_keep_reg <= reg_wdata_in[`AMC_SRST_KEEP_MSB:`AMC_SRST_KEEP_LSB];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (file_reset) begin
      amp_cfg_reg <= `AMC_RST_AMP_CFG;
    end else if (wr_cfg) begin
      amp_cfg_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (file_reset) begin
      state_ctrl_reg <= `AMC_RST_STATE_CTRL;
    end else if (wr_state) begin
      state_ctrl_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (file_reset) begin
      page_inc_reg <= `AMC_RST_PAGE_INC;
    end else if (wr_page) begin
      page_inc_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `AMC_OFS_SOFT_RESET: reg_rdata_out <= {srst_keep_reg, 5'h00};
        `AMC_OFS_AMP_CFG: reg_rdata_out <= amp_cfg_reg;
        `AMC_OFS_STATE_CTRL: reg_rdata_out <= state_ctrl_reg;
        `AMC_OFS_PAGE_INC: reg_rdata_out <= page_inc_reg;
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      switch_freq_khz_out <= 10'h000;
    end else begin
      switch_freq_khz_out <=
        freq_khz(amp_cfg_reg[`AMC_FSW_MSB:`AMC_FSW_LSB]);
    end
  end

  assign switch_freq_select_out = amp_cfg_reg[`AMC_FSW_MSB:`AMC_FSW_LSB];
  assign bridge_topology_select_out = amp_cfg_reg[`AMC_TOPO_BIT];
  assign modulation_scheme_select_out =
    amc_mod_e'(amp_cfg_reg[`AMC_MOD_MSB:`AMC_MOD_LSB]);
  assign processor_hold_reset_out = state_ctrl_reg[`AMC_HOLD_BIT];
  assign mute_req_out = state_ctrl_reg[`AMC_MUTE_BIT];
  assign power_state_out =
    amc_pstate_e'(state_ctrl_reg[`AMC_PSTATE_MSB:`AMC_PSTATE_LSB]);
  assign page_inc_disable_out = page_inc_reg[`AMC_PAGE_INC_DIS_BIT];

  // The ramp belongs to the digital chain, so a core reset restarts it
  amc_ramp #(
    .STEP_CYCLES(RAMP_STEP_CYCLES)
  ) u_ramp (
    .mclk_in(mclk_in),
    .rst_in(rst_in || core_reset_out),
    .mute_req_in(mute_req_out),
    .atten_out(mute_atten_out),
    .muted_out(muted_out)
  );

  // Checks of the register port and of the reset triggers
  sequence core_write_s;
    wr_srst && reg_wdata_in[`AMC_CORE_RST_BIT];
  endsequence
  sequence single_pulse_s;
    core_reset_out && coef_clear_out ##1
      !core_reset_out && !coef_clear_out;
  endsequence
  sequence cfg_write_s;
    wr_cfg && !file_reset;
  endsequence
  sequence state_write_s;
    wr_state && !file_reset;
  endsequence

  chk_core_pulse_once: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    core_write_s ##1 !core_pulse |-> single_pulse_s)
    else $error("core reset not a single pulse");
  chk_no_stray_pulse: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !core_pulse |=> !core_reset_out && !coef_clear_out)
    else $error("reset pulse without a core trigger write");
  chk_core_clears_regs: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    core_write_s |=> state_ctrl_reg == `AMC_RST_STATE_CTRL &&
      amp_cfg_reg == `AMC_RST_AMP_CFG && page_inc_reg == `AMC_RST_PAGE_INC)
    else $error("core reset left registers set");
  chk_core_restarts_ramp: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    core_write_s |=> ##1 mute_atten_out == 8'h00)
    else $error("core reset did not restart the volume ramp");
  chk_regs_keep_coef: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    regs_pulse && !core_pulse |=> !coef_clear_out &&
      state_ctrl_reg == `AMC_RST_STATE_CTRL &&
      amp_cfg_reg == `AMC_RST_AMP_CFG &&
      page_inc_reg == `AMC_RST_PAGE_INC && srst_keep_reg == 3'h0)
    else $error("register reset wrong");
  chk_keep_bits: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    wr_srst && !file_reset |=> srst_keep_reg ==
      $past(reg_wdata_in[`AMC_SRST_KEEP_MSB:`AMC_SRST_KEEP_LSB]))
    else $error("spare bits of the trigger register not stored");
  chk_trigger_reads_zero: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == `AMC_OFS_SOFT_RESET |=>
      reg_rdata_out[`AMC_CORE_RST_BIT:`AMC_REGS_RST_BIT] == 5'h00)
    else $error("trigger bit read back nonzero");
  chk_freq_480: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    cfg_write_s && reg_wdata_in[`AMC_FSW_MSB:`AMC_FSW_LSB] == 3'h3 |=>
      ##1 switch_freq_khz_out == 10'h1E0)
    else $error("480 kHz code not decoded");
  chk_freq_576: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    cfg_write_s && reg_wdata_in[`AMC_FSW_MSB:`AMC_FSW_LSB] == 3'h4 |=>
      ##1 switch_freq_khz_out == 10'h240)
    else $error("576 kHz code not decoded");
  chk_topo_mod_write: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    cfg_write_s |=>
      bridge_topology_select_out == $past(reg_wdata_in[`AMC_TOPO_BIT]) &&
      modulation_scheme_select_out ==
        amc_mod_e'($past(reg_wdata_in[`AMC_MOD_MSB:`AMC_MOD_LSB])))
    else $error("topology or modulation not taken");
  chk_hold_release: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    state_write_s && !reg_wdata_in[`AMC_HOLD_BIT] |=>
      !processor_hold_reset_out)
    else $error("processor hold not released");
  chk_mute_write: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    state_write_s |=> mute_req_out == $past(reg_wdata_in[`AMC_MUTE_BIT]))
    else $error("mute request not taken");
  chk_pstate_write: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    state_write_s |=> power_state_out ==
      amc_pstate_e'($past(reg_wdata_in[`AMC_PSTATE_MSB:`AMC_PSTATE_LSB])))
    else $error("power state not taken");
  chk_reset_value: assert property (
    @(posedge mclk_in)
    rst_in |=> state_ctrl_reg == `AMC_RST_STATE_CTRL &&
      processor_hold_reset_out && !mute_req_out &&
      power_state_out == amc_deep_sleep)
    else $error("state register reset value wrong");
  // Unmapped offsets must never echo stale data back to the host
  chk_unmapped_read: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    reg_rd_in && !(reg_addr_in inside {`AMC_OFS_SOFT_RESET, `AMC_OFS_AMP_CFG,
      `AMC_OFS_STATE_CTRL, `AMC_OFS_PAGE_INC}) |=> reg_rdata_out == 8'h00)
    else $error("unmapped offset read nonzero");
  chk_rdata_holds: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
endmodule

//--- rtl/amc_ramp.sv
// Soft mute volume ramp for both channels
`include "amc_regs.svh"
module amc_ramp
  import amc_pkg::*;
#(
  parameter int STEP_CYCLES = `AMC_RAMP_STEP_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic mute_req_in,
  output logic [7:0] atten_out,
  output logic muted_out
);
  amc_ramp_e state_reg;
  logic [15:0] tick_reg;
  logic tick;

  // One attenuation step per tick keeps the slope gentle enough to avoid pops
  assign tick = (tick_reg == 16'(STEP_CYCLES - 1));

  always_ff @(posedge mclk_in) begin
    if (rst_in || tick) begin
      tick_reg <= 16'h0000;
    end else begin
      tick_reg <= tick_reg + 16'h0001;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg <= amc_ramp_steady;
    end else begin
      case (state_reg)
        amc_ramp_steady: begin
          if (mute_req_in && atten_out != `AMC_ATTEN_MAX) begin
            state_reg <= amc_ramp_down;
          end else if (!mute_req_in && atten_out != 8'h00) begin
            state_reg <= amc_ramp_up;
          end
        end
        amc_ramp_down: begin
          if (!mute_req_in) begin
            state_reg <= amc_ramp_up;
          end else if (atten_out == `AMC_ATTEN_MAX) begin
            state_reg <= amc_ramp_steady;
          end
        end
        amc_ramp_up: begin
          if (mute_req_in) begin
            state_reg <= amc_ramp_down;
          end else if (atten_out == 8'h00) begin
            state_reg <= amc_ramp_steady;
          end
        end
        default: state_reg <= amc_ramp_steady;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      atten_out <= 8'h00;
    // Steps follow the live request, so a reversal never takes a wrong step
    end else if (tick && state_reg == amc_ramp_down && mute_req_in &&
                 atten_out != `AMC_ATTEN_MAX) begin
      atten_out <= atten_out + 8'h01;
    end else if (tick && state_reg == amc_ramp_up && !mute_req_in &&
                 atten_out != 8'h00) begin
      atten_out <= atten_out - 8'h01;
    end
  end

  assign muted_out = (atten_out == `AMC_ATTEN_MAX);

  chk_ramp_step_dir: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    $changed(atten_out) && !$past(rst_in) |->
      ((atten_out == $past(atten_out) + 8'h01) && $past(mute_req_in)) ||
      ((atten_out == $past(atten_out) - 8'h01) && !$past(mute_req_in)))
    else $error("ramp moved the wrong way or by more than one step");
endmodule

//--- shared/amc_pkg.sv
// Types shared by the amplifier control registers
package amc_pkg;
  typedef enum logic [1:0] {
    amc_deep_sleep = 2'h0,
    amc_sleep = 2'h1,
    amc_hiz = 2'h2,
    amc_play = 2'h3
  } amc_pstate_e;
  typedef enum logic [1:0] {
    amc_two_level_differential_mod = 2'h0,
    amc_single_sided_pwm = 2'h1,
    amc_hybrid_mod = 2'h2,
    amc_mod_reserved = 2'h3
  } amc_mod_e;
  typedef enum {
    amc_ramp_steady,
    amc_ramp_down,
    amc_ramp_up
  } amc_ramp_e;
endpackage

//--- shared/amc_regs.svh
// Register offsets, field positions, reset values and timing counts
// Summary of operation
// - Writing 1 to core trigger resets core, registers and coefficients.
// - Writing 1 to register trigger restores registers, keeps coefficients.
// - Both reset triggers are write-only pulses that read back as 0.
// - Switch frequency field: 000 768k, 001 384k, 011 480k, 100 576k.
// - Bridge topology bit: 0 normal bridge-tied stereo, 1 parallel bridge.
// - Modulation field: 00 two-level differential, 01 single-sided, 10 hybrid.
// - Processor hold resets to 1; clearing it releases the audio processor.
// - Mute bit ramps both channels smoothly down, and up again when cleared.
// - Power state field: 00 deep sleep, 01 sleep, 10 Hi-Z, 11 play.
// - State and processor control register resets to 0x10.
`ifndef AMC_REGS_SVH
`define AMC_REGS_SVH
`define AMC_OFS_SOFT_RESET 8'h01
`define AMC_OFS_AMP_CFG 8'h02
`define AMC_OFS_STATE_CTRL 8'h03
`define AMC_OFS_PAGE_INC 8'h0F
`define AMC_RST_SOFT_RESET 8'h00
`define AMC_RST_AMP_CFG 8'h00
`define AMC_RST_STATE_CTRL 8'h10
`define AMC_RST_PAGE_INC 8'h00
`define AMC_CORE_RST_BIT 4
`define AMC_REGS_RST_BIT 0
`define AMC_SRST_KEEP_MSB 7
`define AMC_SRST_KEEP_LSB 5
`define AMC_FSW_MSB 6
`define AMC_FSW_LSB 4
`define AMC_TOPO_BIT 2
`define AMC_MOD_MSB 1
`define AMC_MOD_LSB 0
`define AMC_HOLD_BIT 4
`define AMC_MUTE_BIT 3
`define AMC_PSTATE_MSB 1
`define AMC_PSTATE_LSB 0
`define AMC_PAGE_INC_DIS_BIT 3
`define AMC_CLK_PERIOD_NS 40
`define AMC_RAMP_STEP_NS 20833
`define AMC_RAMP_STEP_CYCLES \
  ((`AMC_RAMP_STEP_NS + `AMC_CLK_PERIOD_NS - 1) / `AMC_CLK_PERIOD_NS)
`define AMC_ATTEN_MAX 8'hFF
`endif
